/* inc/host_irq_defines.vh */
`ifndef HOST_IRQ_DEFINES_VH
`define HOST_IRQ_DEFINES_VH

// register selects on the documented register port
`define REG_SEL_W                1
`define REG_SEL_ENABLE_SET       1'h0
`define REG_SEL_ENABLE_CLEAR     1'h1

// live enable bits within a 32-bit word
`define ENABLE_MASK              32'h0F000066
`define SOFT_IRQ_HI              27
`define SOFT_IRQ_LO              24
`define PARITY_FAULT_BIT         6
`define SYSTEM_FAULT_BIT         5
`define INITIATOR_ABORT_BIT      2
`define COMPLETER_ABORT_BIT      1

// reset value of the internal enable register
`define ENABLE_RESET             32'h00000000

// power state encoding
`define PWR_STATE_W              2
`define PWR_STATE_D0             2'h0

`endif

/* tb/host_irq_enable_set_clear_tb.sv */
`timescale 1ns/1ps
module host_irq_enable_set_clear_tb;
	reg mclk_in = 0, reset_in = 1, wr = 0, rd = 0, sel = 0;
	reg [31:0] wd = 0, e = 0, x, e0, lq = 0;
	reg [33:0] r = 0;
	wire [31:0] st, q, en;
	wire [1:0] pw;
	wire v, pin;
	integer seed = 48388, failures = 0, tests_run = 0, i, cyc = 0;
	always #2.5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) if (++cyc > 5000) begin failures++; wrap_up; end
	host_side p(.r_in(r), .status_out(st), .pwr_out(pw));
	host_irq_enable_set_clear dut(.mclk_in(mclk_in), .reset_in(reset_in), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_sel_in(sel), .reg_wdata_in(wd), .status_in(st), .pwr_state_in(pw),
		.reg_rdata_out(q), .rd_valid_out(v), .enable_out(en), .host_irq_pin_n_out(pin));
	// compare and count
	task chk(input [31:0] g, input [31:0] w); begin
		tests_run++;
		if (g !== w) begin failures++; $display("[ERR] %0t got %h exp %h", $time, g, w); end
	end endtask
	task wrap_up; begin
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	end endtask
	// reset, then random accesses with all-ones corners first
	initial begin
		repeat (16) @(negedge mclk_in);
		reset_in = 0;
		chk(en, 0);
		chk(pin, 1);
		$display("reset test done");
		for (i = 0; i < 400; i++) begin
			e0 = e;
			x = $random(seed);
			{rd, wr, sel} = i < 4 ? {1'b1, 1'b1, i[0]} : x[2:0];
			wd = i < 4 ? 32'hFFFFFFFF : $random(seed) & (x[3] ? 32'h0F000066 : ~0);
			r = {x[5:4] & {2{x[6]}}, 32'h0 + $random(seed)};
			if (wr) e = sel ? e & ~wd : e | (wd & 32'h0F000066);
			@(negedge mclk_in);
			chk(en, e);
			chk(v, rd);
			if (rd) lq = sel ? r[31:0] & e0 : e0;
			chk(q, lq);
			chk(pin, !(|(r[31:0] & e0) && r[33:32] == 0));
		end
		$display("random test done");
		wrap_up;
	end
endmodule // host_irq_enable_set_clear_tb
bind host_irq_enable_set_clear irq_chk c(.*);

/* tb/host_side.sv */
`timescale 1ns/1ps
// status and power state seen behind the host's accesses
module host_side(input wire [33:0] r_in,output wire [31:0] status_out,output wire [1:0] pwr_out);
	assign status_out = r_in[31:0];
	assign pwr_out = r_in[33:32];
endmodule // host_side

/* tb/irq_chk_props.sv */
`timescale 1ns/1ps
module irq_chk(input wire mclk_in,reset_in,reg_wr_in,reg_rd_in,input wire [0:0] reg_sel_in,
	input wire [31:0] reg_wdata_in,status_in,input wire [1:0] pwr_state_in,
	input wire [31:0] reg_rdata_out,enable_out,input wire rd_valid_out,host_irq_pin_n_out);
	// live bits of the written word
	wire [31:0] m = reg_wdata_in & 32'h0F000066;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	a_set_ones: assert property (reg_wr_in && !reg_sel_in |=>
		(enable_out & $past(m)) == $past(m)) else $error("set lost");
	a_clr_ones: assert property (reg_wr_in && reg_sel_in |=>
		(enable_out & $past(m)) == 0) else $error("clear lost");
	a_resv_zero: assert property ((enable_out & ~32'h0F000066) == 0) else $error("resv");
	a_idle_hold: assert property (!reg_wr_in |=> $stable(enable_out)) else $error("drift");
	a_rd_pulse: assert property (reg_rd_in |=> rd_valid_out) else $error("no valid");
	a_rd_set: assert property (reg_rd_in && !reg_sel_in |=>
		reg_rdata_out == $past(enable_out)) else $error("set read");
	a_rd_clr: assert property (reg_rd_in && reg_sel_in |=>
		reg_rdata_out == $past(status_in & enable_out)) else $error("clear read");
	a_pin_d0: assert property (1 |=> host_irq_pin_n_out ==
		!($past(|(status_in & enable_out)) && $past(pwr_state_in) == 0)) else $error("pin");
endmodule // irq_chk

/* verilog/enable_bit_cell.v */
`timescale 1ns/1ps
`include "host_irq_defines.vh"

// one enable bit: write-one-to-set, write-one-to-clear
module enable_bit_cell (
	input  wire mclk_in,   // register clock
	input  wire reset_in,  // async reset, active high
	input  wire set_in,    // set pulse
	input  wire clear_in,  // clear pulse
	output reg  enable_out // stored enable
);

	// set and clear come from different registers, never the same cycle
	always @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			enable_out <= 1'b0;
		end else if (set_in) begin
			enable_out <= 1'b1;
		end else if (clear_in) begin
			enable_out <= 1'b0;
		end
	end

endmodule // enable_bit_cell

/* verilog/host_irq_enable_set_clear.v */
`timescale 1ns/1ps
`include "host_irq_defines.vh"

// Function
// - write-one to set-register bits 27-24 sets software enables
// - set-register bit 6 one sets parity fault enable
// - set-register bit 5 one sets system fault enable
// - set-register bit 2 one sets initiator abort enable
// - set-register bit 1 one sets completer abort enable
// - write-one to clear-register bits 27-24 clears software enables
// - clear-register bit 6 one clears parity fault enable
// - clear-register bit 5 one clears system fault enable
// - clear-register bit 2 one clears initiator abort enable
// - clear-register bit 1 one clears completer abort enable
// - interrupt pin low when flag and enable both set, D0 only
// - set reads enables; clear reads flags AND enables
module host_irq_enable_set_clear (
	input  wire                     mclk_in,      // register clock
	input  wire                     reset_in,     // async reset, active high
	input  wire                     reg_wr_in,    // write strobe, one cycle
	input  wire                     reg_rd_in,    // read strobe, one cycle
	input  wire [`REG_SEL_W-1:0]    reg_sel_in,   // 0 set register, 1 clear register
	input  wire [31:0]              reg_wdata_in, // write data
	input  wire [31:0]              status_in,    // internal status register
	input  wire [`PWR_STATE_W-1:0]  pwr_state_in, // power state, 0 is D0
	output reg  [31:0]              reg_rdata_out,// read data, from flops
	output reg                      rd_valid_out, // read data valid pulse
	output wire [31:0]              enable_out,   // internal enable register
	output reg                      host_irq_pin_n_out // host interrupt, active low
);

	// timing: a write lands at the edge that takes it
	// a read answers one cycle later and its data holds until the next read
	// the pin follows the masked status one cycle later
	// reserved bits are dropped on write and read back as zero
	// a write and a read in one cycle both act

	// register access decode
	wire        write_set;              // write to the enable-set register
	wire        write_clear;            // write to the enable-clear register

	// set pulses per field, from the enable-set register
	wire [3:0]  soft_set;               // software enables to set
	wire        parity_set;             // parity fault enable to set
	wire        system_set;             // system fault enable to set
	wire        initiator_set;          // initiator abort enable to set
	wire        completer_set;          // completer abort enable to set

	// clear pulses per field, from the enable-clear register
	wire [3:0]  soft_clear;             // software enables to clear
	wire        parity_clear;           // parity fault enable to clear
	wire        system_clear;           // system fault enable to clear
	wire        initiator_clear;        // initiator abort enable to clear
	wire        completer_clear;        // completer abort enable to clear

	// stored enables, one cell per live bit
	wire [3:0]  software_irq_bits;      // software interrupt enables
	wire        parity_fault_enable;    // parity fault enable
	wire        system_fault_enable;    // system fault enable
	wire        initiator_abort_enable; // initiator abort enable
	wire        completer_abort_enable; // completer abort enable

	// status flags by field, from outside the block
	wire [3:0]  software_irq_flags;     // software interrupt flags
	wire        parity_fault_flag;      // parity fault flag
	wire        system_fault_flag;      // system fault flag
	wire        initiator_abort_flag;   // initiator abort flag
	wire        completer_abort_flag;   // completer abort flag

	// status gated by enables, per field
	wire [3:0]  masked_soft;            // flagged and enabled software bits
	wire        masked_parity;          // flagged and enabled parity fault
	wire        masked_system;          // flagged and enabled system fault
	wire        masked_initiator;       // flagged and enabled initiator abort
	wire        masked_completer;       // flagged and enabled completer abort

	// assembled masked word and interrupt term
	wire [31:0] masked_status;          // masked word, register layout
	wire        any_masked;             // some enabled source is flagged

	// next values of the output registers
	reg  [31:0] rdata_next;             // next read data
	reg         rd_valid_next;          // next read valid
	reg         pin_n_next;             // next pin level

	// decode writes by register select
	assign write_set   = reg_wr_in && (reg_sel_in == `REG_SEL_ENABLE_SET);
	assign write_clear = reg_wr_in && (reg_sel_in == `REG_SEL_ENABLE_CLEAR);

	// set pulses; only live positions are looked at, reserved bits dropped
	// a zero written leaves its enable alone
	assign soft_set[0]     = write_set & reg_wdata_in[`SOFT_IRQ_LO];
	assign soft_set[1]     = write_set & reg_wdata_in[`SOFT_IRQ_LO + 1];
	assign soft_set[2]     = write_set & reg_wdata_in[`SOFT_IRQ_LO + 2];
	assign soft_set[3]     = write_set & reg_wdata_in[`SOFT_IRQ_HI];
	assign parity_set      = write_set & reg_wdata_in[`PARITY_FAULT_BIT];
	assign system_set      = write_set & reg_wdata_in[`SYSTEM_FAULT_BIT];
	assign initiator_set   = write_set & reg_wdata_in[`INITIATOR_ABORT_BIT];
	assign completer_set   = write_set & reg_wdata_in[`COMPLETER_ABORT_BIT];

	// clear pulses; same positions as the set register
	// a zero written leaves its enable alone
	assign soft_clear[0]   = write_clear & reg_wdata_in[`SOFT_IRQ_LO];
	assign soft_clear[1]   = write_clear & reg_wdata_in[`SOFT_IRQ_LO + 1];
	assign soft_clear[2]   = write_clear & reg_wdata_in[`SOFT_IRQ_LO + 2];
	assign soft_clear[3]   = write_clear & reg_wdata_in[`SOFT_IRQ_HI];
	assign parity_clear    = write_clear & reg_wdata_in[`PARITY_FAULT_BIT];
	assign system_clear    = write_clear & reg_wdata_in[`SYSTEM_FAULT_BIT];
	assign initiator_clear = write_clear & reg_wdata_in[`INITIATOR_ABORT_BIT];
	assign completer_clear = write_clear & reg_wdata_in[`COMPLETER_ABORT_BIT];

	// set has priority inside a cell, but the two pulses never meet:
	// a write goes to one register only, and one write is taken per cycle
	// the enable word itself is never written directly

	// software enable 0
	// bit 24 of both registers
	enable_bit_cell u_soft0 (
		.mclk_in    (mclk_in),
		.reset_in   (reset_in),
		.set_in     (soft_set[0]),
		.clear_in   (soft_clear[0]),
		.enable_out (software_irq_bits[0])
	);

	// software enable 1
	// bit 25 of both registers
	enable_bit_cell u_soft1 (
		.mclk_in    (mclk_in),
		.reset_in   (reset_in),
		.set_in     (soft_set[1]),
		.clear_in   (soft_clear[1]),
		.enable_out (software_irq_bits[1])
	);

	// software enable 2
	// bit 26 of both registers
	enable_bit_cell u_soft2 (
		.mclk_in    (mclk_in),
		.reset_in   (reset_in),
		.set_in     (soft_set[2]),
		.clear_in   (soft_clear[2]),
		.enable_out (software_irq_bits[2])
	);

	// software enable 3
	// bit 27 of both registers
	enable_bit_cell u_soft3 (
		.mclk_in    (mclk_in),
		.reset_in   (reset_in),
		.set_in     (soft_set[3]),
		.clear_in   (soft_clear[3]),
		.enable_out (software_irq_bits[3])
	);

	// parity fault enable
	// bit 6 of both registers
	enable_bit_cell u_parity (
		.mclk_in    (mclk_in),
		.reset_in   (reset_in),
		.set_in     (parity_set),
		.clear_in   (parity_clear),
		.enable_out (parity_fault_enable)
	);

	// system fault enable
	// bit 5 of both registers
	enable_bit_cell u_system (
		.mclk_in    (mclk_in),
		.reset_in   (reset_in),
		.set_in     (system_set),
		.clear_in   (system_clear),
		.enable_out (system_fault_enable)
	);

	// initiator abort enable
	// bit 2 of both registers
	enable_bit_cell u_initiator (
		.mclk_in    (mclk_in),
		.reset_in   (reset_in),
		.set_in     (initiator_set),
		.clear_in   (initiator_clear),
		.enable_out (initiator_abort_enable)
	);

	// completer abort enable
	// bit 1 of both registers
	enable_bit_cell u_completer (
		.mclk_in    (mclk_in),
		.reset_in   (reset_in),
		.set_in     (completer_set),
		.clear_in   (completer_clear),
		.enable_out (completer_abort_enable)
	);

	// enable word; reserved positions read as zero
	assign enable_out[31:28] = 4'h0;
	assign enable_out[24]    = software_irq_bits[0];
	assign enable_out[25]    = software_irq_bits[1];
	assign enable_out[26]    = software_irq_bits[2];
	assign enable_out[27]    = software_irq_bits[3];
	assign enable_out[23:7]  = 17'h00000;
	assign enable_out[6]     = parity_fault_enable;
	assign enable_out[5]     = system_fault_enable;
	assign enable_out[4:3]   = 2'h0;
	assign enable_out[2]     = initiator_abort_enable;
	assign enable_out[1]     = completer_abort_enable;
	assign enable_out[0]     = 1'h0;

	// status fields by position
	assign software_irq_flags[0] = status_in[`SOFT_IRQ_LO];
	assign software_irq_flags[1] = status_in[`SOFT_IRQ_LO + 1];
	assign software_irq_flags[2] = status_in[`SOFT_IRQ_LO + 2];
	assign software_irq_flags[3] = status_in[`SOFT_IRQ_HI];
	assign parity_fault_flag     = status_in[`PARITY_FAULT_BIT];
	assign system_fault_flag     = status_in[`SYSTEM_FAULT_BIT];
	assign initiator_abort_flag  = status_in[`INITIATOR_ABORT_BIT];
	assign completer_abort_flag  = status_in[`COMPLETER_ABORT_BIT];

	// per-field masked status
	assign masked_soft[0]   = software_irq_flags[0] & software_irq_bits[0];
	assign masked_soft[1]   = software_irq_flags[1] & software_irq_bits[1];
	assign masked_soft[2]   = software_irq_flags[2] & software_irq_bits[2];
	assign masked_soft[3]   = software_irq_flags[3] & software_irq_bits[3];
	assign masked_parity    = parity_fault_flag & parity_fault_enable;
	assign masked_system    = system_fault_flag & system_fault_enable;
	assign masked_initiator = initiator_abort_flag & initiator_abort_enable;
	assign masked_completer = completer_abort_flag & completer_abort_enable;

	// masked word in register layout
	// the pin and the clear-register read see the same word, so the host
	// finds the source that raised the pin
	assign masked_status[31:28] = 4'h0;
	assign masked_status[24]    = masked_soft[0];
	assign masked_status[25]    = masked_soft[1];
	assign masked_status[26]    = masked_soft[2];
	assign masked_status[27]    = masked_soft[3];
	assign masked_status[23:7]  = 17'h00000;
	assign masked_status[6]     = masked_parity;
	assign masked_status[5]     = masked_system;
	assign masked_status[4:3]   = 2'h0;
	assign masked_status[2]     = masked_initiator;
	assign masked_status[1]     = masked_completer;
	assign masked_status[0]     = 1'h0;

	// any enabled source that is flagged
	assign any_masked = |masked_status;

	// read data next value; held when no read is taken
	always @* begin
		rdata_next    = reg_rdata_out;
		rd_valid_next = reg_rd_in;
		if (reg_rd_in) begin
			case (reg_sel_in)
				`REG_SEL_ENABLE_SET: begin
					rdata_next = enable_out;
				end
				`REG_SEL_ENABLE_CLEAR: begin
					rdata_next = masked_status;
				end
				default: begin
					rdata_next = reg_rdata_out;
				end
			endcase
		end
	end

	// read data and valid flops
	// valid rises for one cycle per taken read
	always @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			reg_rdata_out <= 32'h00000000;
			rd_valid_out  <= 1'h0;
		end else begin
			reg_rdata_out <= rdata_next;
			rd_valid_out  <= rd_valid_next;
		end
	end

	// interrupt next value; D1 to D3 keep the pin released
	always @* begin
		pin_n_next = 1'h1;
		case (pwr_state_in)
			`PWR_STATE_D0: begin
				pin_n_next = ~any_masked;
			end
			default: begin
				pin_n_next = 1'h1;
			end
		endcase
	end

	// pin flop; idle high out of reset
	// registered so decode glitches never reach the pin
	always @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			host_irq_pin_n_out <= 1'h1;
		end else begin
			host_irq_pin_n_out <= pin_n_next;
		end
	end

endmodule // host_irq_enable_set_clear
